// *** logic/lfd_config_top.sv ***
// Functional notes
// - Gigabit-disable bit set: never run the link at 1000 Mb/s.
// - Drive-class bit set selects class A drive, clear selects class B.
// - Class A applies to gigabit only; 10 and 100 stay class B.
// - Non-active gigabit-disable bit forbids 1000 Mb/s outside the active state.
// - Sleep speed-reduction bit allows lower speed outside the active state.
// - Active speed-reduction bit allows lower speed in the active state.
// - Indicator B blink enable loads from its bit; zero means steady.
// - Indicator B invert loads from its bit; zero means active-low output.
// - Blink-rate bit picks 200 ms or 83 ms on and off.
// - Indicator B display code loads from bits 3:0; code 3 shows activity.
// - Indicator C blink and invert load from bits 15 and 14.
// - Indicator C display code loads from bits 11:8; code 6 shows 100 Mb/s.
// - Indicator A blink and invert load from bits 7 and 6.
// - Indicator A display code loads from bits 3:0; code 2 shows link up.
// - Indicator C and A blink rates come from stored bits 13 and 5.
`default_nettype none
module lfd_config_top #(
	parameter int unsigned SLOW_HALF_CYCLES = lfd_pkg::SLOW_HALF_CYCLES,
	parameter int unsigned FAST_HALF_CYCLES = lfd_pkg::FAST_HALF_CYCLES,
	parameter int CNT_W = 25
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// configuration memory load
	input wire logic nvm_word_valid,
	input wire logic [7:0] nvm_word_index,
	input wire logic [15:0] nvm_word_data,
	input wire logic nvm_load_done,
	// power and link state
	input wire logic active_power_state,
	input wire logic power_policy_reduce,
	input wire logic link_up,
	input wire logic [1:0] link_speed,
	input wire logic link_activity,
	// phy control
	output logic phy_allow_1000,
	output logic phy_reduce_speed,
	output logic driver_class_select,
	// indicator pins: a, b, c
	output logic [2:0] indicator_pin
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] led1_and_phy_defaults_word;
	logic [15:0] reserved_config_word;
	logic [15:0] revision_word;
	logic [15:0] led0_led2_defaults_word;
	logic [15:0] next_led1_and_phy_defaults_word;
	logic [15:0] next_led0_led2_defaults_word;
	logic config_loaded;
	logic wr_pend;
	logic [7:0] wr_idx;
	logic take;
	logic [7:0] addr_idx;
	logic bus_wr_b;
	logic bus_wr_ac;
	logic [31:0] rd_value;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------

	// every transfer completes with no wait state and OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = hsel & htrans[1] & hready;
	assign addr_idx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : lfd_pkg::IDX_NONE;

	// address phase capture for writes
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_idx <= lfd_pkg::IDX_NONE;
		end else if (hready) begin
			wr_pend <= take & hwrite;
			wr_idx <= addr_idx;
		end
	end

	assign bus_wr_b = wr_pend & (wr_idx == lfd_pkg::IDX_LED1_PHY);
	assign bus_wr_ac = wr_pend & (wr_idx == lfd_pkg::IDX_LED02);

	// next values; a bus write wins over a memory load
	always_comb begin
		next_led1_and_phy_defaults_word = led1_and_phy_defaults_word;
		next_led0_led2_defaults_word = led0_led2_defaults_word;
		if (nvm_word_valid && nvm_word_index == lfd_pkg::IDX_LED1_PHY) begin
			next_led1_and_phy_defaults_word = nvm_word_data;
		end
		if (nvm_word_valid && nvm_word_index == lfd_pkg::IDX_LED02) begin
			next_led0_led2_defaults_word = nvm_word_data;
		end
		if (bus_wr_b) begin
			next_led1_and_phy_defaults_word = hwdata[15:0];
		end
		if (bus_wr_ac) begin
			next_led0_led2_defaults_word = hwdata[15:0];
		end
	end

	// writable configuration words
	always_ff @(posedge clock) begin
		if (rst) begin
			led1_and_phy_defaults_word <= lfd_pkg::RST_LED1_PHY;
			led0_led2_defaults_word <= lfd_pkg::RST_LED02;
		end else begin
			led1_and_phy_defaults_word <= next_led1_and_phy_defaults_word;
			led0_led2_defaults_word <= next_led0_led2_defaults_word;
		end
	end

	// reserved words take memory contents only
	always_ff @(posedge clock) begin
		if (rst) begin
			reserved_config_word <= lfd_pkg::RST_RSVD;
			revision_word <= lfd_pkg::RST_REV;
		end else if (nvm_word_valid) begin
			if (nvm_word_index == lfd_pkg::IDX_RSVD) begin
				reserved_config_word <= nvm_word_data;
			end
			if (nvm_word_index == lfd_pkg::IDX_REV) begin
				revision_word <= nvm_word_data;
			end
		end
	end

	// load completion flag, held until reset
	always_ff @(posedge clock) begin
		if (rst) begin
			config_loaded <= 1'b0;
		end else if (nvm_load_done) begin
			config_loaded <= 1'b1;
		end
	end

	// read mux sees the two writable words as they stand after this edge
	always_comb begin
		rd_value = 32'h0000_0000;
		case (addr_idx)
			lfd_pkg::IDX_LED1_PHY: rd_value[15:0] = next_led1_and_phy_defaults_word;
			lfd_pkg::IDX_RSVD: rd_value[15:0] = reserved_config_word;
			lfd_pkg::IDX_REV: rd_value[15:0] = revision_word;
			lfd_pkg::IDX_LED02: rd_value[15:0] = next_led0_led2_defaults_word;
			lfd_pkg::IDX_STATUS: begin
				rd_value[lfd_pkg::ST_LOADED_BIT] = config_loaded;
				rd_value[lfd_pkg::ST_ALLOW_1000_BIT] = phy_allow_1000;
				rd_value[lfd_pkg::ST_REDUCE_BIT] = phy_reduce_speed;
				rd_value[lfd_pkg::ST_CLASS_A_BIT] = driver_class_select;
				rd_value[lfd_pkg::ST_PIN_LSB +: 3] = indicator_pin;
			end
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// read data register, loaded at the address phase edge
	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= rd_value;
		end
	end

	// ------------------------------------------------------------
	// phy speed policy
	// ------------------------------------------------------------

	// gigabit permission, class select and speed reduction
	always_ff @(posedge clock) begin
		if (rst) begin
			phy_allow_1000 <= 1'b1;
			phy_reduce_speed <= 1'b0;
			driver_class_select <= 1'b0;
		end else begin
			phy_allow_1000 <= !led1_and_phy_defaults_word[lfd_pkg::GIGA_DIS_BIT]
				&& !(led1_and_phy_defaults_word[lfd_pkg::NONACT_GIGA_DIS_BIT]
				&& !active_power_state);
			phy_reduce_speed <= power_policy_reduce && (active_power_state
				? led1_and_phy_defaults_word[lfd_pkg::ACTIVE_REDUCE_BIT]
				: led1_and_phy_defaults_word[lfd_pkg::SLEEP_REDUCE_BIT]);
			driver_class_select <= led1_and_phy_defaults_word[lfd_pkg::CLASS_A_BIT]
				&& (link_speed == lfd_pkg::SPEED_1000);
		end
	end

	// ------------------------------------------------------------
	// blink timebases, slow in entry 0 and fast in entry 1
	// ------------------------------------------------------------
	logic [1:0] blink_phase;
	logic [CNT_W-1:0] blink_cnt [2];

	generate
		for (genvar r = 0; r < 2; r++) begin : g_rate
			localparam int unsigned HALF = (r == 1) ? FAST_HALF_CYCLES : SLOW_HALF_CYCLES;
			// counts own clock cycles and flips the phase each half period
			always_ff @(posedge clock) begin
				if (rst) begin
					blink_cnt[r] <= '0;
					blink_phase[r] <= 1'b1;
				end else if (blink_cnt[r] == CNT_W'(HALF - 1)) begin
					blink_cnt[r] <= '0;
					blink_phase[r] <= ~blink_phase[r];
				end else begin
					blink_cnt[r] <= blink_cnt[r] + 1'b1;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// indicators
	// ------------------------------------------------------------
	logic [2:0] ind_blink;
	logic [2:0] ind_invert;
	logic [2:0] ind_rate;
	logic [3:0] ind_mode [3];

	// indicator a from the a/c word
	assign ind_blink[0] = led0_led2_defaults_word[lfd_pkg::A_BLINK_BIT];
	assign ind_invert[0] = led0_led2_defaults_word[lfd_pkg::A_INV_BIT];
	assign ind_rate[0] = led0_led2_defaults_word[lfd_pkg::A_RATE_BIT];
	assign ind_mode[0] = led0_led2_defaults_word[lfd_pkg::A_MODE_LSB +: lfd_pkg::MODE_W];

	// indicator b from the phy word
	assign ind_blink[1] = led1_and_phy_defaults_word[lfd_pkg::B_BLINK_BIT];
	assign ind_invert[1] = led1_and_phy_defaults_word[lfd_pkg::B_INV_BIT];
	assign ind_rate[1] = led1_and_phy_defaults_word[lfd_pkg::B_RATE_BIT];
	assign ind_mode[1] = led1_and_phy_defaults_word[lfd_pkg::B_MODE_LSB +: lfd_pkg::MODE_W];

	// indicator c from the a/c word
	assign ind_blink[2] = led0_led2_defaults_word[lfd_pkg::C_BLINK_BIT];
	assign ind_invert[2] = led0_led2_defaults_word[lfd_pkg::C_INV_BIT];
	assign ind_rate[2] = led0_led2_defaults_word[lfd_pkg::C_RATE_BIT];
	assign ind_mode[2] = led0_led2_defaults_word[lfd_pkg::C_MODE_LSB +: lfd_pkg::MODE_W];

	generate
		for (genvar i = 0; i < 3; i++) begin : g_ind
			lfd_indicator u_ind (
				.clock(clock),
				.rst(rst),
				.blink_enable(ind_blink[i]),
				.polarity_invert(ind_invert[i]),
				.blink_rate(ind_rate[i]),
				.display_select(ind_mode[i]),
				.blink_phase(blink_phase),
				.link_up(link_up),
				.link_speed(link_speed),
				.link_activity(link_activity),
				.indicator_pin(indicator_pin[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_GIGA_OFF: assert property (@(posedge clock) disable iff (rst)
		led1_and_phy_defaults_word[lfd_pkg::GIGA_DIS_BIT] |=> !phy_allow_1000)
		else $error("gigabit allowed while disabled");
	AST_GIGA_NONACTIVE: assert property (@(posedge clock) disable iff (rst)
		led1_and_phy_defaults_word[lfd_pkg::NONACT_GIGA_DIS_BIT] && !active_power_state
		|=> !phy_allow_1000)
		else $error("gigabit allowed outside the active state");
	AST_CLASS_A: assert property (@(posedge clock) disable iff (rst)
		led1_and_phy_defaults_word[lfd_pkg::CLASS_A_BIT] && link_speed == lfd_pkg::SPEED_1000
		|=> driver_class_select)
		else $error("class A not selected at gigabit");
	AST_CLASS_B_LOW: assert property (@(posedge clock) disable iff (rst)
		link_speed != lfd_pkg::SPEED_1000 |=> !driver_class_select)
		else $error("class A below gigabit");
	AST_SLEEP_REDUCE: assert property (@(posedge clock) disable iff (rst)
		power_policy_reduce && !active_power_state
		|=> phy_reduce_speed == $past(led1_and_phy_defaults_word[lfd_pkg::SLEEP_REDUCE_BIT]))
		else $error("sleep speed reduction wrong");
	AST_ACTIVE_REDUCE: assert property (@(posedge clock) disable iff (rst)
		power_policy_reduce && active_power_state
		|=> phy_reduce_speed == $past(led1_and_phy_defaults_word[lfd_pkg::ACTIVE_REDUCE_BIT]))
		else $error("active speed reduction wrong");
	AST_LOAD_B_WORD: assert property (@(posedge clock) disable iff (rst)
		nvm_word_valid && nvm_word_index == lfd_pkg::IDX_LED1_PHY && !bus_wr_b
		|=> led1_and_phy_defaults_word == $past(nvm_word_data))
		else $error("phy word not loaded");
	AST_LOAD_AC_WORD: assert property (@(posedge clock) disable iff (rst)
		nvm_word_valid && nvm_word_index == lfd_pkg::IDX_LED02 && !bus_wr_ac
		|=> led0_led2_defaults_word == $past(nvm_word_data))
		else $error("indicator word not loaded");
	AST_SLOW_FLIP: assert property (@(posedge clock) disable iff (rst)
		blink_cnt[0] == CNT_W'(SLOW_HALF_CYCLES - 1) |=> blink_phase[0] != $past(blink_phase[0]))
		else $error("slow phase did not flip");
	AST_FAST_HOLD: assert property (@(posedge clock) disable iff (rst)
		blink_cnt[1] != CNT_W'(FAST_HALF_CYCLES - 1) |=> $stable(blink_phase[1]))
		else $error("fast phase flipped early");
endmodule
`default_nettype wire

// *** logic/lfd_pkg.sv ***
`default_nettype none
package lfd_pkg;
	// ------------------------------------------------------------
	// word indexes; the byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_LED1_PHY = 8'h1C;
	localparam logic [7:0] IDX_RSVD = 8'h1D;
	localparam logic [7:0] IDX_REV = 8'h1E;
	localparam logic [7:0] IDX_LED02 = 8'h1F;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam logic [7:0] IDX_NONE = 8'hFF;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int GIGA_DIS_BIT = 14;
	localparam int CLASS_A_BIT = 12;
	localparam int NONACT_GIGA_DIS_BIT = 11;
	localparam int SLEEP_REDUCE_BIT = 10;
	localparam int ACTIVE_REDUCE_BIT = 9;
	localparam int B_BLINK_BIT = 7;
	localparam int B_INV_BIT = 6;
	localparam int B_RATE_BIT = 5;
	localparam int B_MODE_LSB = 0;
	localparam int C_BLINK_BIT = 15;
	localparam int C_INV_BIT = 14;
	localparam int C_RATE_BIT = 13;
	localparam int C_MODE_LSB = 8;
	localparam int A_BLINK_BIT = 7;
	localparam int A_INV_BIT = 6;
	localparam int A_RATE_BIT = 5;
	localparam int A_MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int ST_LOADED_BIT = 0;
	localparam int ST_ALLOW_1000_BIT = 1;
	localparam int ST_REDUCE_BIT = 2;
	localparam int ST_CLASS_A_BIT = 3;
	localparam int ST_PIN_LSB = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_LED1_PHY = 16'h2D84;
	localparam logic [15:0] RST_RSVD = 16'h0100;
	localparam logic [15:0] RST_REV = 16'h4300;
	localparam logic [15:0] RST_LED02 = 16'h0706;

	// ------------------------------------------------------------
	// link speed and display codes
	// ------------------------------------------------------------
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	localparam logic [3:0] SHOW_LINK_10 = 4'h0;
	localparam logic [3:0] SHOW_LINK_UP = 4'h2;
	localparam logic [3:0] SHOW_ACTIVITY = 4'h3;
	localparam logic [3:0] SHOW_LINK_ACT = 4'h4;
	localparam logic [3:0] SHOW_LINK_100 = 4'h6;
	localparam logic [3:0] SHOW_LINK_1000 = 4'h7;
	localparam logic [3:0] SHOW_ON = 4'hE;
	localparam logic [3:0] SHOW_OFF = 4'hF;

	// ------------------------------------------------------------
	// blink timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 64'h0000_0000_05F5_E100;
	localparam longint unsigned MS_PER_S = 64'h0000_0000_0000_03E8;
	localparam longint unsigned SLOW_BLINK_MS = 64'h0000_0000_0000_00C8;
	localparam longint unsigned FAST_BLINK_MS = 64'h0000_0000_0000_0053;
	localparam int unsigned SLOW_HALF_CYCLES = 32'(SLOW_BLINK_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned FAST_HALF_CYCLES = 32'(FAST_BLINK_MS * CLK_HZ / MS_PER_S);
endpackage
`default_nettype wire

// *** logic/lfd_indicator.sv ***
`default_nettype none
module lfd_indicator (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// indicator settings
	input wire logic blink_enable,
	input wire logic polarity_invert,
	input wire logic blink_rate,
	input wire logic [3:0] display_select,
	// shared blink phases, slow in bit 0
	input wire logic [1:0] blink_phase,
	// link state
	input wire logic link_up,
	input wire logic [1:0] link_speed,
	input wire logic link_activity,
	// pin
	output logic indicator_pin
);
	logic show;
	logic lit;

	// event selected by the display code
	always_comb begin
		case (display_select)
			lfd_pkg::SHOW_LINK_10: show = link_up & (link_speed == lfd_pkg::SPEED_10);
			lfd_pkg::SHOW_LINK_UP: show = link_up;
			lfd_pkg::SHOW_ACTIVITY: show = link_up & link_activity;
			lfd_pkg::SHOW_LINK_ACT: show = link_up;
			lfd_pkg::SHOW_LINK_100: show = link_up & (link_speed == lfd_pkg::SPEED_100);
			lfd_pkg::SHOW_LINK_1000: show = link_up & (link_speed == lfd_pkg::SPEED_1000);
			lfd_pkg::SHOW_ON: show = 1'b1;
			default: show = 1'b0;
		endcase
	end

	// blink gating first, polarity after it
	assign lit = show & (~blink_enable | blink_phase[blink_rate]);

	// registered pin; inactive level is high for active-low
	always_ff @(posedge clock) begin
		if (rst) begin
			indicator_pin <= 1'b1;
		end else begin
			indicator_pin <= polarity_invert ? lit : ~lit;
		end
	end

	AST_PIN_IDLE_LEVEL: assert property (@(posedge clock) disable iff (rst)
		!show |=> indicator_pin == !$past(polarity_invert))
		else $error("idle indicator not at its inactive level");
	AST_PIN_STEADY: assert property (@(posedge clock) disable iff (rst)
		show && !blink_enable |=> indicator_pin == $past(polarity_invert))
		else $error("non-blinking indicator not lit");
endmodule
`default_nettype wire

// *** dv/lfd_nvm_model.sv ***
`default_nettype none
module lfd_nvm_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// image and start
	input wire logic start,
	input wire logic [15:0] img_b,
	input wire logic [15:0] img_ac,
	// word stream
	output logic nvm_word_valid,
	output logic [7:0] nvm_word_index,
	output logic [15:0] nvm_word_data,
	output logic nvm_load_done,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] step;

	// -----------------------------------------------------------
	// sequencer: b word, a/c word, a stray index, then done
	// -----------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			step <= 3'h0;
			nvm_word_valid <= 1'b0;
			nvm_word_index <= 8'h00;
			nvm_word_data <= 16'h0000;
			nvm_load_done <= 1'b0;
		end else begin
			nvm_word_valid <= 1'b0;
			nvm_load_done <= 1'b0;
			nvm_word_index <= ~nvm_word_index; // idle lines carry no stale word
			nvm_word_data <= ~nvm_word_data;
			if (step == 3'h0) begin
				step <= start ? 3'h1 : 3'h0;
			end else begin
				step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
				case (step)
					3'h1: begin
						nvm_word_valid <= 1'b1;
						nvm_word_index <= lfd_pkg::IDX_LED1_PHY;
						nvm_word_data <= img_b;
					end
					3'h2: begin
						nvm_word_valid <= 1'b1;
						nvm_word_index <= lfd_pkg::IDX_LED02;
						nvm_word_data <= {img_ac[15:5], 1'b0, img_ac[3:0]};
					end
					3'h3: begin
						nvm_word_valid <= 1'b1;
						nvm_word_index <= 8'h21;
						nvm_word_data <= 16'hFFFF;
					end
					default: nvm_load_done <= 1'b1;
				endcase
			end
		end
	end

	// busy while a load runs
	assign busy = (step != 3'h0);
endmodule
`default_nettype wire

// *** dv/led_phy_config_defaults_test.sv ***
`default_nettype none
module led_phy_config_defaults_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOW_H = 20;
	localparam int FAST_H = 8;
	localparam int LIMIT = 20000;
	localparam logic [31:0] A_B = {22'h0, lfd_pkg::IDX_LED1_PHY, 2'h0};
	localparam logic [31:0] A_R = {22'h0, lfd_pkg::IDX_RSVD, 2'h0};
	localparam logic [31:0] A_V = {22'h0, lfd_pkg::IDX_REV, 2'h0};
	localparam logic [31:0] A_AC = {22'h0, lfd_pkg::IDX_LED02, 2'h0};
	localparam logic [31:0] A_ST = {22'h0, lfd_pkg::IDX_STATUS, 2'h0};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, link_speed = 2'h1;
	logic [2:0] hsize = 3'h2, indicator_pin;
	logic hreadyout, hresp, phy_allow_1000, phy_reduce_speed, driver_class_select;
	logic active_power_state = 1'b1, power_policy_reduce = 1'b0;
	logic link_up = 1'b0, link_activity = 1'b0, start = 1'b0, busy;
	logic [15:0] img_b = 16'h2D83, img_ac = 16'h0612;
	logic nvm_word_valid, nvm_load_done;
	logic [7:0] nvm_word_index;
	logic [15:0] nvm_word_data;
	int fails = 0, n_compared = 0, cycles = 0;

	// design and memory model
	lfd_config_top #(.SLOW_HALF_CYCLES(SLOW_H), .FAST_HALF_CYCLES(FAST_H), .CNT_W(25)) dut (
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .nvm_word_valid(nvm_word_valid), .nvm_word_index(nvm_word_index),
		.nvm_word_data(nvm_word_data), .nvm_load_done(nvm_load_done),
		.active_power_state(active_power_state), .power_policy_reduce(power_policy_reduce),
		.link_up(link_up), .link_speed(link_speed), .link_activity(link_activity),
		.phy_allow_1000(phy_allow_1000), .phy_reduce_speed(phy_reduce_speed),
		.driver_class_select(driver_class_select), .indicator_pin(indicator_pin));
	lfd_nvm_model nvm (.clock(clock), .rst(rst), .start(start), .img_b(img_b), .img_ac(img_ac),
		.nvm_word_valid(nvm_word_valid), .nvm_word_index(nvm_word_index),
		.nvm_word_data(nvm_word_data), .nvm_load_done(nvm_load_done), .busy(busy));

	// clock and watchdog
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			summarize();
		end
	end

	// -----------------------------------------------------------
	// bus and compare tasks
	// -----------------------------------------------------------
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic ahb_wr(input logic [31:0] addr, input logic [31:0] wd);
		logic [31:0] dummy;
		ahb_xfer(1'b1, addr, wd, dummy);
	endtask

	task automatic expect_rd(input logic [31:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		ahb_xfer(1'b0, addr, 32'h0, rd);
		check(rd, exp);
	endtask

	// settle n edges, then sample half a cycle later
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic half_period(input int k, output int n);
		logic last;
		int w;
		last = indicator_pin[k];
		w = 0;
		while (indicator_pin[k] === last && w < 200) begin
			@(negedge clock);
			w++;
		end
		last = indicator_pin[k];
		n = 0;
		while (indicator_pin[k] === last && n < 200) begin
			@(negedge clock);
			n++;
		end
	endtask

	// -----------------------------------------------------------
	// test sequence
	// -----------------------------------------------------------
	initial begin
		logic [15:0] w;
		logic [2:0] pins [7] = '{3'b000, 3'b010, 3'b100, 3'b111, 3'b000, 3'b100, 3'b011};
		logic [15:0] tb [7] = '{16'h0003, 16'h0003, 16'h0003, 16'h0043, 16'h0043, 16'h000E, 16'h000F};
		logic [15:0] tac [7] = '{16'h0602, 16'h0602, 16'h0602, 16'h4642, 16'h4642, 16'h0700, 16'h0700};
		logic [15:0] bac [2] = '{16'hA682, 16'h86A2};
		logic [15:0] bb [2] = '{16'h00A4, 16'h0084};
		int n;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		settle(1);
		check({29'h0, indicator_pin}, 32'h7);
		check({31'h0, hresp}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		check({31'h0, phy_allow_1000}, 32'h1);
		expect_rd(A_B, {16'h0, lfd_pkg::RST_LED1_PHY});
		expect_rd(A_R, {16'h0, lfd_pkg::RST_RSVD});
		expect_rd(A_V, {16'h0, lfd_pkg::RST_REV});
		expect_rd(A_AC, {16'h0, lfd_pkg::RST_LED02});
		expect_rd(A_ST, 32'h0000_0072);
		// image load from the memory model
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		// look at busy between edges, never in the edge that moves it
		@(negedge clock);
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(negedge clock);
			n++;
		end
		check({31'h0, busy}, 32'h0);
		expect_rd(A_B, {16'h0, img_b});
		expect_rd(A_AC, {16'h0, img_ac & 16'hFFEF});
		expect_rd(A_ST, 32'h0000_0073);
		// refused and read-only places
		ahb_wr(A_R, 32'h0000_FFFF);
		expect_rd(A_R, {16'h0, lfd_pkg::RST_RSVD});
		ahb_wr(32'h0000_0100, 32'h0000_FFFF);
		expect_rd(32'h0000_0100, 32'h0);
		ahb_wr(A_B, 32'hFFFF_1234);
		expect_rd(A_B, 32'h0000_1234);
		// phy policy over every bit, power state, policy and speed mix
		for (int i = 0; i < 64; i++) begin
			@(posedge clock);
			active_power_state <= i[4];
			power_policy_reduce <= i[5];
			link_speed <= 2'(i % 3);
			w = {1'b0, i[0], 1'b0, i[1] ^ i[3], i[1], i[2], i[3], 9'h000};
			ahb_wr(A_B, {16'h0, w});
			settle(2);
			check({31'h0, phy_allow_1000}, {31'h0, !i[0] && !(i[1] && !i[4])});
			check({31'h0, phy_reduce_speed}, {31'h0, i[5] && (i[4] ? i[3] : i[2])});
			check({31'h0, driver_class_select}, {31'h0, (i[1] ^ i[3]) && (i % 3 == 2)});
		end
		// steady indicators: display codes and inversion; last two rounds cover codes 0, 7, 14, 15
		for (int i = 0; i < 7; i++) begin
			@(posedge clock);
			link_up <= (i != 4);
			link_speed <= (i == 2 || i == 6) ? lfd_pkg::SPEED_1000 : (i == 5) ? lfd_pkg::SPEED_10 : lfd_pkg::SPEED_100;
			link_activity <= (i != 1);
			ahb_wr(A_B, {16'h0, tb[i]});
			ahb_wr(A_AC, {16'h0, tac[i]});
			settle(2);
			check({29'h0, indicator_pin}, {29'h0, pins[i]});
		end
		// blinking indicators at both rates
		@(posedge clock);
		link_up <= 1'b1;
		link_speed <= lfd_pkg::SPEED_100;
		for (int c = 0; c < 2; c++) begin
			ahb_wr(A_B, {16'h0, bb[c]});
			ahb_wr(A_AC, {16'h0, bac[c]});
			settle(2);
			half_period(0, n);
			check(32'(n), bac[c][5] ? 32'(FAST_H) : 32'(SLOW_H));
			half_period(1, n);
			check(32'(n), bb[c][5] ? 32'(FAST_H) : 32'(SLOW_H));
			half_period(2, n);
			check(32'(n), bac[c][13] ? 32'(FAST_H) : 32'(SLOW_H));
		end
		summarize();
	end
endmodule
`default_nettype wire
